// >>> sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    import wd_pkg::*;

    logic clk_i;
    logic rst_i;
    wb_req_t wb_req;
    wb_rsp_t wb_rsp_o;
    logic [3:0] osc_i;
    logic debug_mode_i;
    logic nmi_req_o;
    logic sys_reset_req_o;
    localparam int CYCLE_LIMIT = 4000;
    int n_fail = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [31:0] nmi_cnt = 32'h0;
    logic [31:0] rst_cnt = 32'h0;
    logic [31:0] n0;
    logic [31:0] r0;
    logic [31:0] rd;

    watchdog_unit dut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_req_i(wb_req),
        .wb_rsp_o(wb_rsp_o),
        .osc_i(osc_i),
        .debug_mode_i(debug_mode_i),
        .nmi_req_o(nmi_req_o),
        .sys_reset_req_o(sys_reset_req_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // Counting high cycles makes a stretched request show up as an extra event.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (nmi_req_o === 1'b1) begin
            nmi_cnt <= nmi_cnt + 1;
        end
        if (sys_reset_req_o === 1'b1) begin
            rst_cnt <= rst_cnt + 1;
        end
    end

    task close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task wb_cycle(input logic w_en, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                  output logic [31:0] q);
        int w;
        w = 0;
        @(posedge clk_i);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w_en, adr: a, sel: 4'h3, dat: d};
        @(posedge clk_i);
        while (wb_rsp_o.ack !== 1'b1 && w < 50) begin
            w++;
            @(posedge clk_i);
        end
        q = wb_rsp_o.dat;
        wb_req <= '0;
        if (w >= 50) begin
            n_fail++;
        end
    endtask

    task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb_cycle(1'b1, a, d, q);
    endtask

    task expect_rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb_cycle(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask

    function automatic logic [31:0] ctl(input logic [1:0] m, input logic c, input logic [3:0] r);
        return (32'(m) << MODE_LSB) | (32'(c) << CLEAR_BIT) | 32'(r);
    endfunction

    // Every source toggles together, so each selected source sees the same edges.
    task pulse_osc(input int n);
        repeat (n) begin
            @(posedge clk_i);
            osc_i <= 4'hf;
            repeat (3) @(posedge clk_i);
            osc_i <= 4'h0;
            repeat (2) @(posedge clk_i);
        end
        repeat (6) @(posedge clk_i);
    endtask

    task run_mode(input logic [1:0] m, input logic [31:0] en, input logic [31:0] er);
        wr(CONTROL_OFS, ctl(m, 1'b1, 4'h0));
        n0 = nmi_cnt;
        r0 = rst_cnt;
        pulse_osc(2);
        check(nmi_cnt - n0, en);
        check(rst_cnt - r0, er);
    endtask

    initial begin
        // A hang anywhere below still ends in the same closing report.
        fork
            begin
                wait (cycles >= CYCLE_LIMIT);
                n_fail++;
                close_out();
            end
        join_none
        rst_i = 1'b1;
        wb_req = '0;
        osc_i = 4'h0;
        debug_mode_i = 1'b0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        expect_rd(PROTECT_OFS, 32'h0);
        expect_rd(CLOCK_OFS, 32'h0);
        expect_rd(CONTROL_OFS, 32'h0000000a);
        expect_rd(COMPARE_OFS, 32'h000003ff);
        expect_rd(COUNT_OFS, 32'h0);
        $display("reset values done");
        wr(COMPARE_OFS, 32'h3);
        expect_rd(COMPARE_OFS, 32'h000003ff);
        wr(PROTECT_OFS, 32'(UNLOCK_KEY));
        wr(COMPARE_OFS, 32'h3);
        expect_rd(COMPARE_OFS, 32'h3);
        wr(PROTECT_OFS, 32'h1234);
        wr(COMPARE_OFS, 32'h5);
        expect_rd(COMPARE_OFS, 32'h3);
        expect_rd(8'h20, 32'h0);
        wr(COUNT_OFS, 32'h5);
        expect_rd(COUNT_OFS, 32'h0);
        $display("protection done");
        wr(PROTECT_OFS, 32'(UNLOCK_KEY));
        wr(CLOCK_OFS, 32'h3);
        wr(CONTROL_OFS, ctl(2'h1, 1'b1, 4'h0));
        wr(PROTECT_OFS, 32'h0);
        expect_rd(CONTROL_OFS, 32'h00000200);
        pulse_osc(3);
        expect_rd(COUNT_OFS, 32'h3);
        check(nmi_cnt, 32'h0);
        pulse_osc(1);
        check(nmi_cnt, 32'h1);
        check(rst_cnt, 32'h0);
        expect_rd(COUNT_OFS, 32'h0);
        expect_rd(CONTROL_OFS, 32'h00000300);
        $display("interval done");
        wr(PROTECT_OFS, 32'(UNLOCK_KEY));
        wr(CONTROL_OFS, ctl(2'h1, 1'b1, 4'h0));
        expect_rd(CONTROL_OFS, 32'h00000200);
        pulse_osc(3);
        wr(CONTROL_OFS, ctl(2'h1, 1'b1, 4'h0));
        pulse_osc(3);
        check(nmi_cnt, 32'h1);
        expect_rd(COUNT_OFS, 32'h3);
        wr(CONTROL_OFS, ctl(2'h1, 1'b1, 4'h0));
        $display("feeding done");
        @(posedge clk_i);
        debug_mode_i <= 1'b1;
        pulse_osc(2);
        expect_rd(COUNT_OFS, 32'h0);
        wr(CLOCK_OFS, 32'h103);
        pulse_osc(2);
        expect_rd(COUNT_OFS, 32'h2);
        @(posedge clk_i);
        debug_mode_i <= 1'b0;
        wr(CLOCK_OFS, 32'h3);
        pulse_osc(1);
        expect_rd(COUNT_OFS, 32'h3);
        $display("debug done");
        wr(COMPARE_OFS, 32'h1);
        run_mode(2'h0, 32'h0, 32'h1);
        run_mode(2'h1, 32'h1, 32'h0);
        run_mode(2'h3, 32'h0, 32'h0);
        run_mode(2'h2, 32'h1, 32'h0);
        r0 = rst_cnt;
        pulse_osc(2);
        check(rst_cnt - r0, 32'h1);
        $display("modes done");
        wr(COMPARE_OFS, 32'h3ff);
        wr(CLOCK_OFS, 32'h1);
        wr(CONTROL_OFS, ctl(2'h3, 1'b1, 4'h5));
        // Any window of 256 source edges holds exactly two ticks at 1/128.
        pulse_osc(256);
        expect_rd(COUNT_OFS, 32'h2);
        expect_rd(CONTROL_OFS, 32'h00000600);
        $display("divider done");
        wr(CLOCK_OFS, 32'h3);
        wr(CONTROL_OFS, ctl(2'h3, 1'b1, RUN_STOP));
        pulse_osc(2);
        expect_rd(COUNT_OFS, 32'h0);
        expect_rd(CONTROL_OFS, 32'h0000060a);
        $display("stop done");
        close_out();
    end
endmodule

// >>> verilog/watchdog_unit.sv
`timescale 1ns/1ps
// Functional notes
// - Ten-bit up counter advanced by divided clock.
// - Software selects clock source and divider.
// - Unfed interval elapse raises reset or NMI.
// - Escalate mode resets after unacknowledged NMI.
// - Protected writes need key; other key locks.
// - Debug without run setting freezes counter.
// - Debug with run setting keeps counting.
// - Counter clear write zeroes the counter.
// - Non-stop run code starts counting.
// - Interval equals compare value plus one.
// - Mode field selects reset, NMI or escalate.
// - NMI sets status; counter clear clears it.
// - Stop code stops; run reads zero.
// - Compare match zeroes counter, counting continues.
module watchdog_unit (
    input wire logic clk_i,
    input wire logic rst_i,
    input wd_pkg::wb_req_t wb_req_i,
    output wd_pkg::wb_rsp_t wb_rsp_o,
    input wire logic [3:0] osc_i,
    input wire logic debug_mode_i,
    output logic nmi_req_o,
    output logic sys_reset_req_o
);
    import wd_pkg::*;

    logic [15:0] system_protect_key;
    logic debug_run_enable;
    logic [1:0] wd_clock_divider_sel;
    logic [1:0] wd_clock_source_sel;
    wd_mode_t wd_action_mode;
    logic wd_nmi_status;
    logic [3:0] wd_run_control;
    logic [9:0] wd_compare_value;
    logic [9:0] count;

    logic ack;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] next_rdata;
    logic bus_req;
    logic commit;
    logic unlocked;
    logic [15:0] old_word;
    logic [15:0] wword;
    logic wr_protect;
    logic wr_clock;
    logic wr_control;
    logic wr_compare;
    logic clear_req;
    logic raw_tick;
    logic wd_counter_clock;
    logic running;
    logic match;

    wd_clock_divider u_divider (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .osc_i(osc_i),
        .src_sel_i(wd_clock_source_sel),
        .div_sel_i(wd_clock_divider_sel),
        .tick_o(raw_tick)
    );

    // Bus slave: ack one cycle after the request, write lands at the ack edge.
    assign bus_req = wb_req_i.cyc && wb_req_i.stb;
    assign commit = bus_req && wb_req_i.we && ack;
    assign unlocked = (system_protect_key == UNLOCK_KEY);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack <= 1'b0;
            rdata <= '0;
        end else begin
            ack <= bus_req && !ack;
            if (bus_req && !ack) begin
                rdata <= next_rdata;
            end
        end
    end

    assign wb_rsp_o.ack = ack;
    assign wb_rsp_o.dat = rdata;

    always_comb begin
        next_rdata = '0;
        old_word = 16'h0000;
        case (wb_req_i.adr)
            PROTECT_OFS: old_word = system_protect_key;
            CLOCK_OFS: begin
                old_word[DBRUN_BIT] = debug_run_enable;
                old_word[DIV_LSB +: 2] = wd_clock_divider_sel;
                old_word[SRC_LSB +: 2] = wd_clock_source_sel;
            end
            CONTROL_OFS: begin
                old_word[MODE_LSB +: 2] = wd_action_mode;
                old_word[NMI_STAT_BIT] = wd_nmi_status;
                old_word[RUN_LSB +: 4] = (wd_run_control == RUN_STOP) ? RUN_STOP
                                                                   : RUN_READ_ACTIVE;
            end
            COMPARE_OFS: old_word[9:0] = wd_compare_value;
            COUNT_OFS: old_word[9:0] = count;
            default: old_word = 16'h0000;
        endcase
        next_rdata[15:0] = old_word;
    end

    // Unselected byte lanes keep what the register already holds.
    assign wword = {wb_req_i.sel[1] ? wb_req_i.dat[15:8] : old_word[15:8],
                    wb_req_i.sel[0] ? wb_req_i.dat[7:0] : old_word[7:0]};

    assign wr_protect = commit && (wb_req_i.adr == PROTECT_OFS);
    assign wr_clock = commit && unlocked && (wb_req_i.adr == CLOCK_OFS);
    assign wr_control = commit && unlocked && (wb_req_i.adr == CONTROL_OFS);
    assign wr_compare = commit && unlocked && (wb_req_i.adr == COMPARE_OFS);
    assign clear_req = wr_control && wb_req_i.sel[0] && wb_req_i.dat[CLEAR_BIT];

    // Any value but the key closes the gate again.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            system_protect_key <= PROTECT_RST;
        end else if (wr_protect) begin
            system_protect_key <= wword;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            debug_run_enable <= 1'b0;
            wd_clock_divider_sel <= 2'h0;
            wd_clock_source_sel <= 2'h0;
        end else if (wr_clock) begin
            debug_run_enable <= wword[DBRUN_BIT];
            wd_clock_divider_sel <= wword[DIV_LSB +: 2];
            wd_clock_source_sel <= wword[SRC_LSB +: 2];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wd_action_mode <= MODE_RESET;
            wd_run_control <= RUN_STOP;
        end else if (wr_control) begin
            wd_action_mode <= wd_mode_t'(wword[MODE_LSB +: 2]);
            if (wb_req_i.sel[0]) begin
                wd_run_control <= wb_req_i.dat[RUN_LSB +: 4];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wd_compare_value <= COMPARE_RST;
        end else if (wr_compare) begin
            wd_compare_value <= wword[9:0];
        end
    end

    // The tick is dropped in debug unless software allows running there.
    assign wd_counter_clock = raw_tick && (!debug_mode_i || debug_run_enable);
    assign running = (wd_run_control != RUN_STOP);
    assign match = wd_counter_clock && running && (count == wd_compare_value);

    // Clearing beats a tick in the same cycle, so a feed always restarts the interval.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= 10'h000;
        end else if (clear_req) begin
            count <= 10'h000;
        end else if (match) begin
            count <= 10'h000;
        end else if (wd_counter_clock && running) begin
            count <= count + 10'h001;
        end
    end

    // Match response; the clear is looked at before the status flag is set, so the set wins.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nmi_req_o <= 1'b0;
            sys_reset_req_o <= 1'b0;
            wd_nmi_status <= 1'b0;
        end else begin
            nmi_req_o <= 1'b0;
            sys_reset_req_o <= 1'b0;
            if (clear_req) begin
                wd_nmi_status <= 1'b0;
            end
            if (match) begin
                case (wd_action_mode)
                    MODE_RESET: sys_reset_req_o <= 1'b1;
                    MODE_NMI: begin
                        nmi_req_o <= 1'b1;
                        wd_nmi_status <= 1'b1;
                    end
                    MODE_ESCALATE: begin
                        if (wd_nmi_status) begin
                            sys_reset_req_o <= 1'b1;
                        end else begin
                            nmi_req_o <= 1'b1;
                            wd_nmi_status <= 1'b1;
                        end
                    end
                    default: begin
                        nmi_req_o <= 1'b0;
                    end
                endcase
            end
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_count_step: assert property (
        wd_counter_clock && running && !clear_req && count != wd_compare_value
        |=> count == $past(count) + 10'h001)
        else $error("counter did not advance by one");

    a_match_wraps: assert property (
        match && !clear_req |=> count == 10'h000)
        else $error("counter not zero after match");

    // A clear that meets a setting match still leaves the flag set, since the set wins.
    a_clear_zero: assert property (
        clear_req |=> count == 10'h000
            && wd_nmi_status == $past(match && (wd_action_mode == MODE_NMI
            || (wd_action_mode == MODE_ESCALATE && !wd_nmi_status))))
        else $error("clear did not reset counter and status");

    a_locked_hold: assert property (
        commit && !unlocked && wb_req_i.adr != PROTECT_OFS
        |=> $stable(wd_compare_value) && $stable(wd_run_control) && $stable(wd_action_mode))
        else $error("write accepted while locked");

    a_reset_mode: assert property (
        match && wd_action_mode == MODE_RESET |=> sys_reset_req_o && !nmi_req_o)
        else $error("reset mode did not raise reset");

    a_escalate_reset: assert property (
        match && wd_action_mode == MODE_ESCALATE && wd_nmi_status && !clear_req
        |=> sys_reset_req_o && !nmi_req_o)
        else $error("escalation did not reset");

    a_nmi_status: assert property (
        nmi_req_o |-> wd_nmi_status && $past(wd_action_mode) != MODE_RESET)
        else $error("NMI without status");

    a_pulse_single: assert property (
        (nmi_req_o || sys_reset_req_o) |=> !nmi_req_o && !sys_reset_req_o)
        else $error("request longer than one cycle");

    a_debug_freeze: assert property (
        debug_mode_i && !debug_run_enable && !clear_req |=> $stable(count))
        else $error("counter moved in debug");

    a_debug_runs: assert property (
        raw_tick && debug_mode_i && debug_run_enable && running && !clear_req
        && count != wd_compare_value
        |=> count == $past(count) + 10'h001)
        else $error("tick lost in debug with run enabled");

    a_run_reads_zero: assert property (
        bus_req && !ack && !wb_req_i.we && wb_req_i.adr == CONTROL_OFS && running
        |=> ack && rdata[3:0] == RUN_READ_ACTIVE)
        else $error("run field read not zero");

    a_stop_reads_code: assert property (
        bus_req && !ack && !wb_req_i.we && wb_req_i.adr == CONTROL_OFS && !running
        |=> ack && rdata[RUN_LSB +: 4] == RUN_STOP)
        else $error("stopped run field not read as stop code");

    a_clear_reads_zero: assert property (
        bus_req && !ack && !wb_req_i.we && wb_req_i.adr == CONTROL_OFS
        |=> !rdata[CLEAR_BIT])
        else $error("counter clear bit read as one");

    a_stopped_hold: assert property (
        !running && !clear_req |=> $stable(count))
        else $error("counter moved while stopped");

    a_status_hold: assert property (
        !clear_req && !match |=> $stable(wd_nmi_status))
        else $error("status changed without match or clear");

    a_nmi_mode: assert property (
        match && wd_action_mode == MODE_NMI
        |=> nmi_req_o && !sys_reset_req_o && wd_nmi_status)
        else $error("NMI mode did not raise NMI");

    a_escalate_nmi: assert property (
        match && wd_action_mode == MODE_ESCALATE && !wd_nmi_status
        |=> nmi_req_o && !sys_reset_req_o && wd_nmi_status)
        else $error("escalation did not start with NMI");

    a_reserved_quiet: assert property (
        match && wd_action_mode == MODE_RESERVED |=> !nmi_req_o && !sys_reset_req_o)
        else $error("reserved mode raised a request");

    a_request_cause: assert property (
        nmi_req_o || sys_reset_req_o |-> $past(match))
        else $error("request without compare match");

    // Only the exact key opens the gate, so a stray write to the key word fails safe.
    a_key_opens: assert property (
        wr_protect && wword == UNLOCK_KEY |=> unlocked)
        else $error("key write did not unlock");

    a_key_closes: assert property (
        wr_protect && wword != UNLOCK_KEY |=> !unlocked)
        else $error("other key did not lock");

    a_compare_write: assert property (
        wr_compare |=> wd_compare_value == $past(wword[9:0]))
        else $error("unlocked compare write lost");

    a_run_write: assert property (
        wr_control && wb_req_i.sel[0]
        |=> wd_run_control == $past(wb_req_i.dat[RUN_LSB +: 4]))
        else $error("run control write lost");

    a_clock_write: assert property (
        wr_clock |=> wd_clock_source_sel == $past(wword[SRC_LSB +: 2])
            && wd_clock_divider_sel == $past(wword[DIV_LSB +: 2]))
        else $error("clock select write lost");

    c_nmi: cover property (nmi_req_o);
    c_reset: cover property (sys_reset_req_o);
    c_escalate: cover property (
        match && wd_action_mode == MODE_ESCALATE && wd_nmi_status);
    c_feed: cover property (clear_req && running);
    c_debug_run: cover property (raw_tick && debug_mode_i && debug_run_enable);

endmodule

// >>> verilog/wd_clock_divider.sv
`timescale 1ns/1ps
module wd_clock_divider (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] osc_i,
    input wire logic [1:0] src_sel_i,
    input wire logic [1:0] div_sel_i,
    output logic tick_o
);
    import wd_pkg::*;

    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic level;
    logic [15:0] prescale;
    logic [15:0] limit;
    logic edge_seen;

    // Oscillators come from other domains; each passes three flops.
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sync
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    sync1[g] <= 1'b0;
                    sync2[g] <= 1'b0;
                    sync3[g] <= 1'b0;
                end else begin
                    sync1[g] <= osc_i[g];
                    sync2[g] <= sync1[g];
                    sync3[g] <= sync2[g];
                end
            end
        end
    endgenerate

    // A level change counts only once stages two and three agree.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level <= 1'b0;
        end else if (sync2[src_sel_i] == sync3[src_sel_i]) begin
            level <= sync3[src_sel_i];
        end
    end

    assign edge_seen = !level && sync2[src_sel_i] && sync3[src_sel_i];

    always_comb begin
        case (wd_src_t'(src_sel_i))
            SRC_IOSC, SRC_OSC3: limit = 16'((32'd1 << (DIV_BASE_LOG2 + int'(div_sel_i))) - 1);
            SRC_OSC1: limit = OSC1_LIMIT;
            default: limit = EXOSC_LIMIT;
        endcase
    end

    // The compare is >= so a smaller ratio chosen mid-count cannot overrun.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prescale <= 16'h0000;
            tick_o <= 1'b0;
        end else begin
            tick_o <= 1'b0;
            if (edge_seen) begin
                if (prescale >= limit) begin
                    prescale <= 16'h0000;
                    tick_o <= 1'b1;
                end else begin
                    prescale <= prescale + 16'h0001;
                end
            end
        end
    end

endmodule

// >>> verilog/wd_pkg.sv
package wd_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [ADDR_W-1:0] adr;
        logic [3:0] sel;
        logic [DATA_W-1:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic ack;
        logic [DATA_W-1:0] dat;
    } wb_rsp_t;

    // Byte addresses of the register words.
    localparam logic [ADDR_W-1:0] PROTECT_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] CLOCK_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] CONTROL_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] COMPARE_OFS = 8'h0c;
    localparam logic [ADDR_W-1:0] COUNT_OFS = 8'h10;

    localparam logic [15:0] UNLOCK_KEY = 16'h0096;
    localparam logic [15:0] PROTECT_RST = 16'h0000;

    // Clock register fields.
    localparam int DBRUN_BIT = 8;
    localparam int DIV_LSB = 4;
    localparam int SRC_LSB = 0;

    // Control register fields.
    localparam int MODE_LSB = 9;
    localparam int NMI_STAT_BIT = 8;
    localparam int CLEAR_BIT = 4;
    localparam int RUN_LSB = 0;

    localparam logic [3:0] RUN_STOP = 4'ha;
    localparam logic [3:0] RUN_READ_ACTIVE = 4'h0;
    localparam logic [9:0] COMPARE_RST = 10'h3ff;

    typedef enum logic [1:0] {
        MODE_RESET = 2'h0,
        MODE_NMI = 2'h1,
        MODE_ESCALATE = 2'h2,
        MODE_RESERVED = 2'h3
    } wd_mode_t;

    typedef enum logic [1:0] {
        SRC_IOSC = 2'h0,
        SRC_OSC1 = 2'h1,
        SRC_OSC3 = 2'h2,
        SRC_EXOSC = 2'h3
    } wd_src_t;

    // Log2 of the base prescaler ratio, then terminal counts, one less than the ratio.
    localparam int DIV_BASE_LOG2 = 13;
    localparam logic [15:0] OSC1_LIMIT = 16'h007f;
    localparam logic [15:0] EXOSC_LIMIT = 16'h0000;

endpackage
